//--- amoc_pkg.sv
package amoc_pkg;

  // ==========================================================
  // operating states
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_OFF = 3'b001,
    ST_STBY = 3'b010,
    ST_WAKE = 3'b011,
    ST_SLEEP = 3'b100
  } amoc_state_t;

  // ==========================================================
  // system mode indicator codes
  localparam logic [1:0] SYSMODE_STBY = 2'h0;
  localparam logic [1:0] SYSMODE_WAKE = 2'h1;
  localparam logic [1:0] SYSMODE_SLEEP = 2'h2;

  // ==========================================================
  // full-scale range codes
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;
  // raw front-end counts per g, shifts to 256, 128, 64 counts/g
  localparam int RAW_PER_G = 1024;
  localparam int SHIFT_2G = 2;
  localparam int SHIFT_4G = 3;
  localparam int SHIFT_8G = 4;

  // ==========================================================
  // register map
  localparam logic [5:0] ADDR_OUT_X_HI = 6'h00;
  localparam logic [5:0] ADDR_OUT_X_LO = 6'h01;
  localparam logic [5:0] ADDR_OUT_Y_HI = 6'h02;
  localparam logic [5:0] ADDR_OUT_Y_LO = 6'h03;
  localparam logic [5:0] ADDR_OUT_Z_HI = 6'h04;
  localparam logic [5:0] ADDR_OUT_Z_LO = 6'h05;
  localparam logic [5:0] ADDR_USER_OFF0 = 6'h06;
  localparam logic [5:0] ADDR_SYSMODE = 6'h0c;
  localparam int NUM_USER_OFF = 6;

  // ==========================================================
  // factory trim store layout and contents
  localparam int TRIM_WORDS = 6;
  localparam int TRIM_GAIN0 = 0;
  localparam int TRIM_OFF0 = 3;
  localparam int GAIN_SHIFT = 7;
  localparam logic [9:0] TRIM_GAIN_DEF = 10'h080;
  localparam logic [9:0] TRIM_OFF_DEF = 10'h000;

  // ==========================================================
  // self-test stimulus in raw counts, per axis
  localparam logic signed [13:0] ST_FORCE_X = 14'sh0040;
  localparam logic signed [13:0] ST_FORCE_Y = 14'sh0040;
  localparam logic signed [13:0] ST_FORCE_Z = 14'sh0100;

  // ==========================================================
  // orientation trip slopes, tan 60 and tan 30 over 1000
  localparam int TAN60_NUM = 1732;
  localparam int TAN30_NUM = 577;
  localparam int TAN_DEN = 1000;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 25;
  localparam int WAKE_PERIOD_US = 1250;
  localparam int SLEEP_PERIOD_US = 20000;
  localparam int WAKE_CYCLES = WAKE_PERIOD_US * CLK_MHZ;
  localparam int SLEEP_CYCLES = SLEEP_PERIOD_US * CLK_MHZ;

endpackage

//--- amoc_trim_mem.sv
`timescale 1ns/1ps
module amoc_trim_mem #(
  parameter int DEPTH = amoc_pkg::TRIM_WORDS,
  parameter int WIDTH = 10
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // read port
  input wire logic [2:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  // ==========================================================
  // nonvolatile contents
  function automatic logic [WIDTH-1:0] trim_word(input logic [2:0] a);
    if (int'(a) < amoc_pkg::TRIM_OFF0)
      trim_word = WIDTH'(amoc_pkg::TRIM_GAIN_DEF);
    else if (int'(a) < DEPTH)
      trim_word = WIDTH'(amoc_pkg::TRIM_OFF_DEF);
    else
      trim_word = '0;
  endfunction

  // ==========================================================
  // registered read
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_data_out <= '0;
    else
      rd_data_out <= trim_word(rd_addr_in);
  end

endmodule

//--- amoc_accel_mode_offset_control.sv
`timescale 1ns/1ps
module amoc_accel_mode_offset_control #(
  parameter int WAKE_DIV = amoc_pkg::WAKE_CYCLES,
  parameter int SLEEP_DIV = amoc_pkg::SLEEP_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // supply state pin
  input wire logic power_good_in,
  // control
  input wire logic active_req_in,
  input wire logic self_test_in,
  input wire logic [1:0] range_in,
  input wire logic [1:0] oversample_in,
  input wire logic low_noise_in,
  input wire logic fast_read_in,
  input wire logic auto_sleep_en_in,
  input wire logic [7:0] sleep_timeout_in,
  input wire logic wake_event_in,
  // raw front-end samples
  input wire logic signed [13:0] raw_x_in,
  input wire logic signed [13:0] raw_y_in,
  input wire logic signed [13:0] raw_z_in,
  // host register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  // status
  output logic bus_enable_out,
  output logic sample_clk_en_out,
  output logic [1:0] system_mode_indicator_out,
  output logic data_ready_out,
  output logic landscape_out,
  output logic signed [9:0] out_x_out,
  output logic signed [9:0] out_y_out,
  output logic signed [9:0] out_z_out
);

  // ==========================================================
  // state
  typedef struct packed {
    logic pg_meta;
    logic pg_sync;
    amoc_pkg::amoc_state_t st;
    logic [2:0] trim_idx;
    logic [2:0][9:0] gain;
    logic [2:0][9:0] foff;
    logic [5:0][7:0] uoff;
    logic [2:0][16:0] acc;
    logic [2:0] osr_cnt;
    logic [19:0] div_cnt;
    logic [7:0] idle_cnt;
    logic [2:0][9:0] outv;
    logic drdy;
    logic land;
    logic [7:0] rdata;
    logic ack;
  } amoc_state_t;

  amoc_state_t s_reg;
  amoc_state_t s_next;
  logic [9:0] trim_rd_data;

  amoc_trim_mem #(
    .DEPTH(amoc_pkg::TRIM_WORDS),
    .WIDTH(10)
  ) u_trim (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .rd_addr_in(s_reg.trim_idx),
    .rd_data_out(trim_rd_data)
  );

  // ==========================================================
  // helpers
  function automatic logic signed [13:0] raw_sel(input int a);
    case (a)
      0: raw_sel = raw_x_in;
      1: raw_sel = raw_y_in;
      default: raw_sel = raw_z_in;
    endcase
  endfunction

  function automatic logic signed [13:0] st_force(input int a);
    case (a)
      0: st_force = amoc_pkg::ST_FORCE_X;
      1: st_force = amoc_pkg::ST_FORCE_Y;
      default: st_force = amoc_pkg::ST_FORCE_Z;
    endcase
  endfunction

  function automatic int range_shift(input logic [1:0] r);
    case (r)
      amoc_pkg::RANGE_2G: range_shift = amoc_pkg::SHIFT_2G;
      amoc_pkg::RANGE_4G: range_shift = amoc_pkg::SHIFT_4G;
      amoc_pkg::RANGE_8G: range_shift = amoc_pkg::SHIFT_8G;
      default: range_shift = amoc_pkg::SHIFT_8G;
    endcase
  endfunction

  function automatic logic signed [9:0] sat10(input logic signed [31:0] v);
    if (v > 32'sh1ff)
      sat10 = 10'sh1ff;
    else if (v < -32'sh200)
      sat10 = -10'sh200;
    else
      sat10 = v[9:0];
  endfunction

  function automatic logic [31:0] abs10(input logic signed [9:0] v);
    abs10 = v[9] ? 32'(-32'(v)) : 32'(v);
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    logic active;
    logic tick;
    logic last_osr;
    logic [2:0] osr_n;
    logic signed [31:0] smp;
    logic signed [31:0] avg;
    logic signed [31:0] val;
    logic signed [31:0] uo;
    logic signed [9:0] nv;
    logic [31:0] ax;
    logic [31:0] ay;
    s_next = s_reg;
    active = 1'b0;
    tick = 1'b0;
    last_osr = 1'b0;
    osr_n = 3'h0;
    smp = '0;
    avg = '0;
    val = '0;
    uo = '0;
    nv = '0;
    ax = '0;
    ay = '0;
    s_next.pg_meta = power_good_in;
    s_next.pg_sync = s_reg.pg_meta;
    s_next.ack = 1'b0;
    s_next.drdy = 1'b0;

    // mode control
    case (s_reg.st)
      amoc_pkg::ST_BOOT:
      begin
        // index n addresses word n, data for n-1 arrives now
        if (s_reg.trim_idx != 3'h0)
        begin
          if (int'(s_reg.trim_idx) <= amoc_pkg::TRIM_OFF0)
            s_next.gain[s_reg.trim_idx - 3'h1] = trim_rd_data;
          else
            s_next.foff[s_reg.trim_idx - 3'h4] = trim_rd_data;
        end
        if (int'(s_reg.trim_idx) == amoc_pkg::TRIM_WORDS)
          s_next.st = amoc_pkg::ST_OFF;
        else
          s_next.trim_idx = s_reg.trim_idx + 3'h1;
      end
      amoc_pkg::ST_OFF:
      begin
        if (s_reg.pg_sync)
          s_next.st = amoc_pkg::ST_STBY;
      end
      amoc_pkg::ST_STBY:
      begin
        if (active_req_in)
        begin
          s_next.st = amoc_pkg::ST_WAKE;
          // data path subset returns to reset values
          s_next.acc = '0;
          s_next.osr_cnt = '0;
          s_next.div_cnt = '0;
          s_next.idle_cnt = '0;
          s_next.outv = '0;
          s_next.land = 1'b0;
        end
      end
      amoc_pkg::ST_WAKE, amoc_pkg::ST_SLEEP:
      begin
        active = 1'b1;
        if (!active_req_in)
          s_next.st = amoc_pkg::ST_STBY;
      end
      default:
        s_next.st = amoc_pkg::ST_OFF;
    endcase
    if (!s_reg.pg_sync && s_reg.st != amoc_pkg::ST_BOOT)
    begin
      s_next.st = amoc_pkg::ST_OFF;
      active = 1'b0;
    end

    // sample rate divider runs only while active
    if (active)
    begin
      if (s_reg.st == amoc_pkg::ST_SLEEP)
        tick = (int'(s_reg.div_cnt) >= SLEEP_DIV - 1);
      else
        tick = (int'(s_reg.div_cnt) >= WAKE_DIV - 1);
      s_next.div_cnt = tick ? 20'h0 : s_reg.div_cnt + 20'h1;
    end

    // auto-sleep on event-free time-out
    if (active && active_req_in)
    begin
      if (wake_event_in)
      begin
        s_next.idle_cnt = '0;
        s_next.st = amoc_pkg::ST_WAKE;
      end
      else if (auto_sleep_en_in && s_reg.st == amoc_pkg::ST_WAKE && tick)
      begin
        if (s_reg.idle_cnt >= sleep_timeout_in)
        begin
          s_next.st = amoc_pkg::ST_SLEEP;
          s_next.idle_cnt = '0;
        end
        else
          s_next.idle_cnt = s_reg.idle_cnt + 8'h1;
      end
      else if (!auto_sleep_en_in && s_reg.st == amoc_pkg::ST_SLEEP)
        s_next.st = amoc_pkg::ST_WAKE;
    end

    // oversampled acquisition
    osr_n = 3'(1 << oversample_in);
    last_osr = (s_reg.osr_cnt == osr_n - 3'h1);
    if (tick)
    begin
      s_next.osr_cnt = last_osr ? 3'h0 : s_reg.osr_cnt + 3'h1;
      for (int a = 0; a < 3; a++)
      begin
        smp = 32'(raw_sel(a));
        if (self_test_in)
          smp = smp + 32'(st_force(a));
        if (last_osr)
        begin
          avg = (32'(signed'(s_reg.acc[a])) + smp) >>> oversample_in;
          // range scaling keeps one g at 256/128/64
          val = avg >>> range_shift(range_in);
          // gain is unsigned, widened first so the product stays signed
          val = (val * signed'(32'(s_reg.gain[a]))) >>> amoc_pkg::GAIN_SHIFT;
          uo = 32'(signed'({s_reg.uoff[2*a], s_reg.uoff[2*a+1]}));
          val = val + 32'(signed'(s_reg.foff[a])) + uo;
          if (low_noise_in)
            val = (val + 32'(signed'(s_reg.outv[a]))) >>> 1;
          nv = sat10(val);
          s_next.outv[a] = nv;
          s_next.acc[a] = '0;
        end
        else
          s_next.acc[a] = 17'(32'(signed'(s_reg.acc[a])) + smp);
      end
      if (last_osr)
      begin
        s_next.drdy = 1'b1;
        // portrait/landscape with hysteresis band
        ax = abs10(s_next.outv[0]);
        ay = abs10(s_next.outv[1]);
        if (!s_reg.land && ax * 32'(amoc_pkg::TAN_DEN) > ay * 32'(amoc_pkg::TAN60_NUM))
          s_next.land = 1'b1;
        else if (s_reg.land && ax * 32'(amoc_pkg::TAN_DEN) < ay * 32'(amoc_pkg::TAN30_NUM))
          s_next.land = 1'b0;
      end
    end

    // host register access, refused while off or booting
    if ((reg_wr_in || reg_rd_in) && s_reg.st != amoc_pkg::ST_OFF
        && s_reg.st != amoc_pkg::ST_BOOT && s_reg.pg_sync)
    begin
      s_next.ack = 1'b1;
      if (reg_wr_in)
      begin
        for (int i = 0; i < amoc_pkg::NUM_USER_OFF; i++)
          if (reg_addr_in == amoc_pkg::ADDR_USER_OFF0 + 6'(i))
            s_next.uoff[i] = reg_wdata_in;
      end
      else
      begin
        case (reg_addr_in)
          amoc_pkg::ADDR_OUT_X_HI: s_next.rdata = s_reg.outv[0][9:2];
          amoc_pkg::ADDR_OUT_Y_HI: s_next.rdata = s_reg.outv[1][9:2];
          amoc_pkg::ADDR_OUT_Z_HI: s_next.rdata = s_reg.outv[2][9:2];
          amoc_pkg::ADDR_OUT_X_LO: s_next.rdata = fast_read_in ? 8'h00 : {s_reg.outv[0][1:0], 6'h00};
          amoc_pkg::ADDR_OUT_Y_LO: s_next.rdata = fast_read_in ? 8'h00 : {s_reg.outv[1][1:0], 6'h00};
          amoc_pkg::ADDR_OUT_Z_LO: s_next.rdata = fast_read_in ? 8'h00 : {s_reg.outv[2][1:0], 6'h00};
          amoc_pkg::ADDR_SYSMODE: s_next.rdata = {6'h00, sysmode(s_reg.st)};
          default:
          begin
            s_next.rdata = 8'h00;
            for (int i = 0; i < amoc_pkg::NUM_USER_OFF; i++)
              if (reg_addr_in == amoc_pkg::ADDR_USER_OFF0 + 6'(i))
                s_next.rdata = s_reg.uoff[i];
          end
        endcase
      end
    end
  end

  // ==========================================================
  // system mode decode
  function automatic logic [1:0] sysmode(input amoc_pkg::amoc_state_t st);
    case (st)
      amoc_pkg::ST_WAKE: sysmode = amoc_pkg::SYSMODE_WAKE;
      amoc_pkg::ST_SLEEP: sysmode = amoc_pkg::SYSMODE_SLEEP;
      default: sysmode = amoc_pkg::SYSMODE_STBY;
    endcase
  endfunction

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_reg <= '0;
      s_reg.st <= amoc_pkg::ST_BOOT;
    end
    else
      s_reg <= s_next;
  end

  // ==========================================================
  // outputs
  assign reg_rdata_out = s_reg.rdata;
  assign reg_ack_out = s_reg.ack;
  assign bus_enable_out = (s_reg.st != amoc_pkg::ST_OFF) && (s_reg.st != amoc_pkg::ST_BOOT);
  assign sample_clk_en_out = (s_reg.st == amoc_pkg::ST_WAKE) || (s_reg.st == amoc_pkg::ST_SLEEP);
  assign system_mode_indicator_out = sysmode(s_reg.st);
  assign data_ready_out = s_reg.drdy;
  assign landscape_out = s_reg.land;
  assign out_x_out = s_reg.outv[0];
  assign out_y_out = s_reg.outv[1];
  assign out_z_out = s_reg.outv[2];

endmodule

//--- amoc_accel_mode_offset_control_properties.sv
`timescale 1ns/1ps
module amoc_chk #(
  parameter int WAKE_DIV = amoc_pkg::WAKE_CYCLES,
  parameter int SLEEP_DIV = amoc_pkg::SLEEP_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // host side
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic fast_read_in,
  input wire logic wake_event_in,
  // status
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic bus_enable_out,
  input wire logic sample_clk_en_out,
  input wire logic [1:0] system_mode_indicator_out,
  input wire logic data_ready_out,
  input wire logic signed [9:0] out_x_out,
  input wire logic signed [9:0] out_y_out,
  input wire logic signed [9:0] out_z_out
);
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_ack;
    (reg_rd_in || reg_wr_in) && bus_enable_out |=> reg_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("access unanswered");
  property p_off_refused;
    (reg_rd_in || reg_wr_in) && !bus_enable_out |=> !reg_ack_out;
  endproperty
  a_off_refused: assert property (p_off_refused) else $error("answered while off");
  property p_mode_clk;
    sample_clk_en_out == (system_mode_indicator_out != amoc_pkg::SYSMODE_STBY);
  endproperty
  a_mode_clk: assert property (p_mode_clk) else $error("mode and clock differ");
  property p_hold;
    bus_enable_out && !sample_clk_en_out && $past(bus_enable_out && !sample_clk_en_out)
      |-> $stable({out_x_out, out_y_out, out_z_out});
  endproperty
  a_hold: assert property (p_hold) else $error("data moved in standby");
  property p_clear;
    $rose(sample_clk_en_out) |-> ##[0:1] ({out_x_out, out_y_out, out_z_out} == 30'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("data not cleared");
  property p_dr;
    data_ready_out |-> $past(sample_clk_en_out) ##1 !data_ready_out;
  endproperty
  a_dr: assert property (p_dr) else $error("bad data ready");
  property p_wake;
    system_mode_indicator_out == amoc_pkg::SYSMODE_SLEEP && wake_event_in
      |-> ##[1:3] (system_mode_indicator_out != amoc_pkg::SYSMODE_SLEEP);
  endproperty
  a_wake: assert property (p_wake) else $error("no return to wake");
  property p_fast;
    reg_rd_in && !reg_wr_in && fast_read_in && bus_enable_out
      && reg_addr_in == amoc_pkg::ADDR_OUT_X_LO |=> reg_rdata_out == 8'h00;
  endproperty
  a_fast: assert property (p_fast) else $error("low byte in fast read");
endmodule

bind amoc_accel_mode_offset_control amoc_chk #(.WAKE_DIV(WAKE_DIV), .SLEEP_DIV(SLEEP_DIV)) u_chk (
  .sys_clk_in, .arst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .fast_read_in, .wake_event_in,
  .reg_rdata_out, .reg_ack_out, .bus_enable_out, .sample_clk_en_out, .system_mode_indicator_out,
  .data_ready_out, .out_x_out, .out_y_out, .out_z_out
);

//--- amoc_host_model.sv
`timescale 1ns/1ps
module amoc_host_model (
  // clock
  input wire logic sys_clk_in,
  // register port
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_ack_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [5:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  initial
  begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 6'h3f;
    reg_wdata_out = 8'h00;
  end
  // ==========================================================
  // one-cycle strobe, answer taken the cycle after
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
    output logic [7:0] rdata, output logic ok);
    @(posedge sys_clk_in) #1;
    reg_wr_out = wr;
    reg_rd_out = !wr;
    reg_addr_out = addr;
    reg_wdata_out = wdata;
    @(posedge sys_clk_in) #1;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~addr;
    reg_wdata_out = ~wdata;
    ok = reg_ack_in;
    rdata = reg_rdata_in;
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // signals
  logic sys_clk_in, arst_n_in, power_good_in, active_req_in, self_test_in, low_noise_in;
  logic fast_read_in, auto_sleep_en_in, wake_event_in, reg_wr_in, reg_rd_in, reg_ack_out;
  logic bus_enable_out, sample_clk_en_out, data_ready_out, landscape_out, rd_ok;
  logic [1:0] range_in, oversample_in, system_mode_indicator_out;
  logic [7:0] sleep_timeout_in, reg_wdata_in, reg_rdata_out, rd_byte, wb;
  logic [5:0] reg_addr_in;
  logic signed [13:0] raw_x_in, raw_y_in, raw_z_in;
  logic signed [9:0] out_x_out, out_y_out, out_z_out, ex, held_x;
  int errors, samples_checked, seed, rx, ry;
  int ox[4] = '{1024, 1000, 0, 1000};
  int oy[4] = '{0, 1000, 1024, 1000};
  logic ol[4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  amoc_accel_mode_offset_control #(.WAKE_DIV(8), .SLEEP_DIV(32)) u_amoc_accel_mode_offset_control (
    .sys_clk_in, .arst_n_in, .power_good_in, .active_req_in, .self_test_in, .range_in,
    .oversample_in, .low_noise_in, .fast_read_in, .auto_sleep_en_in, .sleep_timeout_in,
    .wake_event_in, .raw_x_in, .raw_y_in, .raw_z_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .bus_enable_out, .sample_clk_en_out,
    .system_mode_indicator_out, .data_ready_out, .landscape_out, .out_x_out, .out_y_out, .out_z_out
  );
  amoc_host_model u_host (
    .sys_clk_in, .reg_rdata_in(reg_rdata_out), .reg_ack_in(reg_ack_out), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in)
  );

  // ==========================================================
  // expectations, compares and waits
  function automatic logic signed [9:0] scaled(input int raw, input int rng, input int off);
    return 10'((raw >>> (rng + 2)) + off);
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_val({15'h0, got}, {15'h0, exp}, what);
  endtask
  task automatic wait_until(input int kind, input logic [1:0] val);
    int n = 0;
    do
    begin
      @(posedge sys_clk_in) #1;
      n++;
    end
    while (n < 400 && !(kind == 0 ? data_ready_out === 1'b1 :
      kind == 1 ? system_mode_indicator_out === val : bus_enable_out === val[0]));
    if (n >= 400)
    begin
      errors++;
      $display("wrong value at %0t: wait ran out", $time);
      conclude();
    end
  endtask
  task automatic sample_check(input int x, input int y, input int z, input int rng, input int st);
    raw_x_in = 14'(x);
    raw_y_in = 14'(y);
    raw_z_in = 14'(z);
    rx = x;
    ry = y;
    wait_until(0, 2'h0);
    wait_until(0, 2'h0);
    ex = scaled(x + st * int'(amoc_pkg::ST_FORCE_X), rng, 3);
    chk_val(out_x_out, ex, "x");
    chk_val(out_y_out, scaled(y + st * int'(amoc_pkg::ST_FORCE_Y), rng, 0), "y");
    chk_val(out_z_out, scaled(z + st * int'(amoc_pkg::ST_FORCE_Z), rng, 0), "z");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 13;
    {errors, samples_checked} = '0;
    {arst_n_in, power_good_in, active_req_in, self_test_in, low_noise_in} = '0;
    {fast_read_in, auto_sleep_en_in, wake_event_in, range_in, oversample_in} = '0;
    sleep_timeout_in = 8'h02;
    {raw_x_in, raw_y_in, raw_z_in} = '0;
    repeat (20) @(posedge sys_clk_in);
    #1;
    arst_n_in = 1'b1;
    repeat (12) @(posedge sys_clk_in);
    #1;
    chk_flag(bus_enable_out, 1'b0, "bus off");
    u_host.access(1'b0, amoc_pkg::ADDR_SYSMODE, 8'h00, rd_byte, rd_ok);
    chk_flag(rd_ok, 1'b0, "ack off");
    power_good_in = 1'b1;
    wait_until(2, 2'h1);
    chk_flag(sample_clk_en_out, 1'b0, "clk stby");
    u_host.access(1'b0, amoc_pkg::ADDR_SYSMODE, 8'h00, rd_byte, rd_ok);
    chk_val(rd_byte[1:0], amoc_pkg::SYSMODE_STBY, "mode");
    for (int i = 0; i < amoc_pkg::NUM_USER_OFF; i++)
    begin
      wb = 8'($random(seed));
      u_host.access(1'b1, amoc_pkg::ADDR_USER_OFF0 + 6'(i), wb, rd_byte, rd_ok);
      u_host.access(1'b0, amoc_pkg::ADDR_USER_OFF0 + 6'(i), 8'h00, rd_byte, rd_ok);
      chk_val(rd_byte, wb, "offset");
      wb = (i == 1) ? 8'h03 : 8'h00;
      u_host.access(1'b1, amoc_pkg::ADDR_USER_OFF0 + 6'(i), wb, rd_byte, rd_ok);
    end
    active_req_in = 1'b1;
    wait_until(1, amoc_pkg::SYSMODE_WAKE);
    chk_flag(sample_clk_en_out, 1'b1, "clk act");
    // range code 3 is taken as the 8 g range
    for (int r = 0; r < 4; r++)
    begin
      range_in = 2'(r);
      for (int k = 0; k < 3; k++)
        sample_check((k == 0) ? -2048 : $random(seed) % 1500, $random(seed) % 1500, 1024,
          (r == 3) ? 2 : r, 0);
      u_host.access(1'b0, amoc_pkg::ADDR_OUT_X_LO, 8'h00, rd_byte, rd_ok);
      chk_val(rd_byte, {ex[1:0], 6'h00}, "x lo");
      u_host.access(1'b0, amoc_pkg::ADDR_OUT_X_HI, 8'h00, rd_byte, rd_ok);
      chk_val(rd_byte, ex[9:2], "x hi");
    end
    for (int o = 0; o < 4; o++)
    begin
      oversample_in = 2'(o);
      sample_check(rx, ry, 1024, 2, 0);
      low_noise_in = 1'b1;
      sample_check(rx, ry, 1024, 2, 0);
      low_noise_in = 1'b0;
    end
    oversample_in = 2'h0;
    self_test_in = 1'b1;
    sample_check(rx, ry, 1024, 2, 1);
    self_test_in = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      sample_check(ox[i], oy[i], 0, 2, 0);
      chk_flag(landscape_out, ol[i], "orient");
    end
    fast_read_in = 1'b1;
    u_host.access(1'b0, amoc_pkg::ADDR_OUT_X_LO, 8'h00, rd_byte, rd_ok);
    chk_val(rd_byte, 8'h00, "fast");
    fast_read_in = 1'b0;
    active_req_in = 1'b0;
    wait_until(1, amoc_pkg::SYSMODE_STBY);
    held_x = out_x_out;
    raw_x_in = 14'sh0100;
    repeat (40) @(posedge sys_clk_in);
    #1;
    chk_val(out_x_out, held_x, "held");
    active_req_in = 1'b1;
    wait_until(1, amoc_pkg::SYSMODE_WAKE);
    chk_val(out_x_out, 16'h0000, "cleared");
    u_host.access(1'b0, amoc_pkg::ADDR_USER_OFF0 + 6'h01, 8'h00, rd_byte, rd_ok);
    chk_val(rd_byte, 8'h03, "kept");
    sample_check(rx, ry, 1024, 2, 0);
    auto_sleep_en_in = 1'b1;
    wait_until(1, amoc_pkg::SYSMODE_SLEEP);
    wake_event_in = 1'b1;
    @(posedge sys_clk_in) #1;
    wake_event_in = 1'b0;
    auto_sleep_en_in = 1'b0;
    wait_until(1, amoc_pkg::SYSMODE_WAKE);
    power_good_in = 1'b0;
    wait_until(2, 2'h0);
    u_host.access(1'b0, amoc_pkg::ADDR_SYSMODE, 8'h00, rd_byte, rd_ok);
    chk_flag(rd_ok, 1'b0, "ack lost");
    conclude();
  end
endmodule
